// ===== verilog/epa_ctrl.sv
// EEPROM page access controller with latches, flags and page cycles.
`timescale 1ns/1ns
module epa_ctrl
    import epa_pkg::*;
(
    input  wire logic               REF_CLK,
    input  wire logic               RST,
    input  wire logic               ADDR_WR,
    input  wire epa_pkg::epa_byte_t ADDR_WDATA,
    input  wire logic               DATA_WR,
    input  wire epa_pkg::epa_byte_t DATA_WDATA,
    input  wire logic               DATA_RD,
    input  wire logic               CTRL_WR,
    input  wire epa_pkg::epa_byte_t CTRL_WDATA,
    input  wire logic               RELOAD_WR,
    input  wire epa_pkg::epa_byte_t RELOAD_WDATA,
    input  wire logic               DERIV_IRQ_EN,
    output epa_pkg::epa_byte_t      ADDR_Q,
    output epa_pkg::epa_byte_t      DATA_RDATA,
    output epa_pkg::epa_byte_t      CTRL_Q,
    output epa_pkg::epa_byte_t      RELOAD_Q,
    output epa_pkg::epa_byte_t      TIMER_COUNT,
    output logic                    TIMER_IRQ
);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ERASE,
        ST_WRITE,
        ST_DONE
    } epa_state_e;

    ////////////////////////////////////////////////////////////////////
    // State.

    epa_state_e state;
    epa_state_e next_state;
    epa_byte_t  addr;
    epa_byte_t  next_addr;
    epa_byte_t  reload;
    epa_byte_t  next_reload;
    logic       irq_en;
    logic       next_irq_en;
    logic       tflag;
    logic       next_tflag;
    logic       busy;
    logic       next_busy;
    logic [2:0] mode;
    logic [2:0] next_mode;
    epa_byte_t  latch      [4];
    epa_byte_t  next_latch [4];
    logic [3:0] sel;
    logic [3:0] next_sel;
    epa_byte_t  rdata;
    epa_byte_t  next_rdata;
    logic       irq;
    logic       next_irq;
    epa_byte_t  mem [256];

    logic       tmr_load;
    logic       tmr_run;
    logic       tmr_uf;
    logic       mem_erase;
    logic       mem_write;
    logic [2:0] new_mode;

    ////////////////////////////////////////////////////////////////////
    // Page timer.

    assign tmr_run = (state == ST_ERASE) || (state == ST_WRITE);

    epa_timer u_timer (
        .clk          (REF_CLK),
        .rst          (RST),
        .load         (tmr_load),
        .run          (tmr_run),
        .reload_value (reload),
        .count        (TIMER_COUNT),
        .underflow    (tmr_uf)
    );

    ////////////////////////////////////////////////////////////////////
    // Next-state logic.

    assign new_mode = CTRL_WDATA[CTRL_MODE_LSB +: 3];

    always_comb begin
        next_state  = state;
        next_addr   = addr;
        next_reload = reload;
        next_irq_en = irq_en;
        next_tflag  = tflag;
        next_busy   = busy;
        next_mode   = mode;
        next_latch  = latch;
        next_sel    = sel;
        tmr_load    = 1'b0;
        mem_erase   = 1'b0;
        mem_write   = 1'b0;

        // Reload and mode changes are only honoured while idle.
        if (RELOAD_WR && (state == ST_IDLE)) begin
            next_reload = RELOAD_WDATA;
        end

        if (CTRL_WR) begin
            next_irq_en = CTRL_WDATA[CTRL_IRQ_EN_BIT];
            next_tflag  = CTRL_WDATA[CTRL_FLAG_BIT];
        end

        unique case (state)
            ST_IDLE: begin
                if (CTRL_WR) begin
                    next_mode = new_mode;
                    next_busy = 1'b0;
                    if (CTRL_WDATA[CTRL_BUSY_BIT]) begin
                        if (new_mode[2:1] == MODE_WRITE_HI) begin
                            next_busy  = 1'b1;
                            next_state = ST_WRITE;
                            tmr_load   = 1'b1;
                        end else if (new_mode == MODE_ERASEWRITE ||
                                     new_mode == MODE_ERASE) begin
                            next_busy  = 1'b1;
                            next_state = ST_ERASE;
                            tmr_load   = 1'b1;
                        end
                    end
                end else if (DATA_WR) begin
                    // Only the index bits pick the latch.
                    next_latch[addr[1:0]] =
                        latch[addr[1:0]] | DATA_WDATA;
                    next_sel[addr[1:0]] = 1'b1;
                    if (mode == MODE_INCREMENT &&
                        addr[1:0] != LAST_LATCH) begin
                        next_addr[1:0] = addr[1:0] + 2'h1;
                    end
                end else if (DATA_RD && mode == MODE_READ) begin
                    next_addr = addr + 8'h01;
                end
                if (ADDR_WR) begin
                    next_addr = ADDR_WDATA;
                end
            end

            ST_ERASE: begin
                if (tmr_uf) begin
                    mem_erase = 1'b1;
                    if (mode == MODE_ERASEWRITE) begin
                        next_state = ST_WRITE;
                        tmr_load   = 1'b1;
                    end else begin
                        next_state = ST_DONE;
                    end
                end
            end

            ST_WRITE: begin
                if (tmr_uf) begin
                    mem_write  = 1'b1;
                    next_state = ST_DONE;
                end
            end

            ST_DONE: begin
                for (int i = 0; i < 4; i++) begin
                    next_latch[i] = LATCH_RESET;
                end
                next_sel   = 4'h0;
                next_busy  = 1'b0;
                next_mode  = MODE_RESET;
                next_tflag = 1'b1;
                if (mode != MODE_ERASE) begin
                    next_addr = addr + 8'h01;
                end
                next_state = ST_IDLE;
            end
        endcase

        next_rdata = mem[next_addr];
        next_irq   = next_tflag && next_irq_en && DERIV_IRQ_EN;
    end

    ////////////////////////////////////////////////////////////////////
    // Registers.

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            state  <= ST_IDLE;
            addr   <= ADDR_RESET;
            reload <= RELOAD_RESET;
            irq_en <= 1'b0;
            tflag  <= 1'b0;
            busy   <= 1'b0;
            mode   <= MODE_RESET;
            sel    <= 4'h0;
            rdata  <= ERASED_BYTE;
            irq    <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                latch[i] <= LATCH_RESET;
            end
        end else begin
            state  <= next_state;
            addr   <= next_addr;
            reload <= next_reload;
            irq_en <= next_irq_en;
            tflag  <= next_tflag;
            busy   <= next_busy;
            mode   <= next_mode;
            sel    <= next_sel;
            rdata  <= next_rdata;
            irq    <= next_irq;
            latch  <= next_latch;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Array: page bytes change only under their select flag.

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            for (int j = 0; j < 256; j++) begin
                mem[j] <= ERASED_BYTE;
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (sel[i]) begin
                    if (mem_erase) begin
                        mem[{addr[7:2], i[1:0]}] <= ERASED_BYTE;
                    end else if (mem_write) begin
                        mem[{addr[7:2], i[1:0]}] <=
                            mem[{addr[7:2], i[1:0]}] | latch[i];
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs.

    assign ADDR_Q     = addr;
    assign DATA_RDATA = rdata;
    assign RELOAD_Q   = reload;
    assign TIMER_IRQ  = irq;
    assign CTRL_Q     = {1'b0, irq_en, tflag, busy, mode, 1'b0};

endmodule

// ===== inc/epa_pkg.sv
// Shared constants and types for the EEPROM page access controller.
//
// Operation
// - Four latches, indexed 0 to 3, never readable.
// - Data port writes OR into latch.
// - All latches cleared when any cycle ends.
// - Latch write also sets its byte select flag.
// - All byte select flags cleared at cycle end.
// - Cycle end clears busy, may raise interrupt.
// - Read mode returns addressed byte without waiting.
// - Write or erase 5 ms; erase/write 10 ms.
// - Page cycles use page bits, flagged bytes only.
// - Erase clears flagged bytes, latches ignored.
// - Write ORs latch into flagged page bytes.
// - Erase/write erases then copies latch exactly.
// - Increment mode steps latch index, stops at 3.
// - Setup latch chosen by index bits only.
// - Byte read increments whole address, wrapping.
// - Write cycles increment whole address, may cross page.
// - Busy control word starts cycle; reload between phases.
// - Mode bits with busy select the operation.
// - Cycle end stops timer, sets flag, clears mode.
package epa_pkg;

    typedef logic [7:0] epa_byte_t;

    // Control word bit positions.
    localparam int CTRL_IRQ_EN_BIT = 6;
    localparam int CTRL_FLAG_BIT   = 5;
    localparam int CTRL_BUSY_BIT   = 4;
    localparam int CTRL_MODE_LSB   = 1;

    // Mode field codes {mode_ctl_bit3, mode_ctl_bit2, mode_ctl_bit1}.
    localparam logic [2:0] MODE_READ       = 3'h0;
    localparam logic [2:0] MODE_INCREMENT  = 3'h2;
    localparam logic [2:0] MODE_ERASEWRITE = 3'h4;
    localparam logic [2:0] MODE_ERASE      = 3'h7;
    localparam logic [1:0] MODE_WRITE_HI   = 2'h1;

    // Reset values and the last latch index.
    localparam epa_byte_t  ADDR_RESET   = 8'h00;
    localparam epa_byte_t  RELOAD_RESET = 8'h00;
    localparam epa_byte_t  LATCH_RESET  = 8'h00;
    localparam epa_byte_t  ERASED_BYTE  = 8'h00;
    localparam logic [2:0] MODE_RESET   = 3'h0;
    localparam logic [1:0] LAST_LATCH   = 2'h3;

    // Page timer: one count per TIMER_DIVIDE reference clocks.
    localparam int         TIMER_DIVIDE   = 480;
    localparam logic [8:0] TIMER_PRE_LAST = 9'(TIMER_DIVIDE - 1);

    // Nominal phase length and the reload value that yields it here.
    localparam int REF_CLK_HZ    = 10_000_000;
    localparam int PHASE_TIME_MS = 5;
    localparam int NOMINAL_RELOAD =
        (PHASE_TIME_MS * (REF_CLK_HZ / 1000)) / TIMER_DIVIDE - 1;

endpackage

// ===== verilog/epa_timer.sv
// Reload down-counter that times each page cycle phase.
`timescale 1ns/1ns
module epa_timer
    import epa_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             load,
    input  wire logic             run,
    input  wire epa_pkg::epa_byte_t reload_value,
    output epa_pkg::epa_byte_t    count,
    output logic                  underflow
);

    logic [8:0] pre;
    logic [8:0] next_pre;
    epa_byte_t  next_count;
    logic       next_underflow;

    always_comb begin
        next_pre       = pre;
        next_count     = count;
        next_underflow = 1'b0;
        if (load) begin
            next_pre   = 9'h000;
            next_count = reload_value;
        end else if (run) begin
            if (pre == TIMER_PRE_LAST) begin
                next_pre = 9'h000;
                if (count == 8'h00) begin
                    // Count zero on a tick is the underflow.
                    next_underflow = 1'b1;
                    next_count     = reload_value;
                end else begin
                    next_count = count - 8'h01;
                end
            end else begin
                next_pre = pre + 9'h001;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pre       <= 9'h000;
            count     <= RELOAD_RESET;
            underflow <= 1'b0;
        end else begin
            pre       <= next_pre;
            count     <= next_count;
            underflow <= next_underflow;
        end
    end

endmodule

// ===== verification/epa_shadow.sv
// Behavioural copy of the EEPROM array that predicts read data.
`timescale 1ns/1ns
module epa_shadow;
    import epa_pkg::*;
    epa_byte_t mem [256] = '{default: ERASED_BYTE};
    // Applies one page cycle to the flagged bytes; er erases them first.
    task automatic op(input logic [5:0] pg, input logic [3:0] f,
                      input logic [31:0] lat, input logic er);
        for (int i = 0; i < 4; i++) begin
            if (f[i]) begin
                mem[{pg, 2'(i)}] = lat[8*i +: 8] |
                    (er ? ERASED_BYTE : mem[{pg, 2'(i)}]);
            end
        end
    endtask
endmodule

// ===== verification/epa_ctrl_asserts.sv
// Concurrent checks on the ports of the EEPROM page access controller.
`timescale 1ns/1ns
module epa_ctrl_chk
    import epa_pkg::*;
(
    input wire logic               REF_CLK,
    input wire logic               RST,
    input wire logic               ADDR_WR,
    input wire logic               DATA_WR,
    input wire logic               DATA_RD,
    input wire logic               CTRL_WR,
    input wire logic               DERIV_IRQ_EN,
    input wire logic               TIMER_IRQ,
    input wire epa_pkg::epa_byte_t CTRL_WDATA,
    input wire epa_pkg::epa_byte_t ADDR_Q,
    input wire epa_pkg::epa_byte_t CTRL_Q,
    input wire epa_pkg::epa_byte_t RELOAD_Q
);
    logic       busy;
    logic [2:0] mode;
    assign busy = CTRL_Q[CTRL_BUSY_BIT];
    assign mode = CTRL_Q[CTRL_MODE_LSB +: 3];
    default clocking @(posedge REF_CLK);
    endclocking
    default disable iff (RST);
    sequence busy_span;
        busy ##1 busy;
    endsequence
    sequence cycle_end;
        $fell(busy);
    endsequence
    chk_busy_start: assert property (
        CTRL_WR && !busy && CTRL_WDATA[4:2] == 3'h5 |=> busy)
        else $error("page write did not start");
    chk_read_step: assert property (
        DATA_RD && !busy && mode == MODE_READ && !ADDR_WR && !CTRL_WR
        && !DATA_WR |=> ADDR_Q == $past(ADDR_Q) + 8'h01)
        else $error("read did not advance address");
    chk_latch_step: assert property (
        DATA_WR && !busy && mode == MODE_INCREMENT && !ADDR_WR && !CTRL_WR
        |=> ADDR_Q[7:2] == $past(ADDR_Q[7:2]) && ADDR_Q[1:0] ==
        ($past(ADDR_Q[1:0]) == LAST_LATCH ? LAST_LATCH
        : $past(ADDR_Q[1:0]) + 2'h1))
        else $error("latch index step wrong");
    chk_end_state: assert property (
        cycle_end |-> mode == MODE_RESET && CTRL_Q[CTRL_FLAG_BIT])
        else $error("cycle end state wrong");
    chk_end_addr: assert property (
        cycle_end |-> ADDR_Q == $past(ADDR_Q)
        + ($past(mode) == MODE_ERASE ? 8'h00 : 8'h01))
        else $error("address after cycle wrong");
    chk_irq_follow: assert property (
        TIMER_IRQ == (CTRL_Q[CTRL_IRQ_EN_BIT]
        && CTRL_Q[CTRL_FLAG_BIT] && $past(DERIV_IRQ_EN)))
        else $error("timer interrupt wrong");
    chk_addr_hold: assert property (
        busy_span |-> $stable(ADDR_Q))
        else $error("address moved during cycle");
    chk_mode_hold: assert property (
        busy_span |-> $stable(mode) && $stable(RELOAD_Q))
        else $error("mode or reload moved during cycle");
endmodule
bind epa_ctrl epa_ctrl_chk i_epa_ctrl_chk (
    .REF_CLK      (REF_CLK),
    .RST          (RST),
    .ADDR_WR      (ADDR_WR),
    .DATA_WR      (DATA_WR),
    .DATA_RD      (DATA_RD),
    .CTRL_WR      (CTRL_WR),
    .DERIV_IRQ_EN (DERIV_IRQ_EN),
    .TIMER_IRQ    (TIMER_IRQ),
    .CTRL_WDATA   (CTRL_WDATA),
    .ADDR_Q       (ADDR_Q),
    .CTRL_Q       (CTRL_Q),
    .RELOAD_Q     (RELOAD_Q)
);

// ===== verification/tb.sv
// Self-checking testbench for the EEPROM page access controller.
`timescale 1ns/1ns
module tb;
    import epa_pkg::*;
    localparam int PHASE = 2 * TIMER_DIVIDE;
    logic      ref_clk, rst, deriv_irq_en, data_rd, timer_irq;
    logic      addr_wr, data_wr, ctrl_wr, reload_wr;
    epa_byte_t wdata, addr_q, data_rdata, ctrl_q, reload_q, timer_count;
    int        miscompares = 0;
    int        cmp_count = 0;
    int        cycles = 0;
    epa_ctrl i_epa_ctrl (
        .REF_CLK(ref_clk),
        .RST(rst),
        .ADDR_WR(addr_wr),
        .ADDR_WDATA(wdata),
        .DATA_WR(data_wr),
        .DATA_WDATA(wdata),
        .DATA_RD(data_rd),
        .CTRL_WR(ctrl_wr),
        .CTRL_WDATA(wdata),
        .RELOAD_WR(reload_wr),
        .RELOAD_WDATA(wdata),
        .DERIV_IRQ_EN(deriv_irq_en),
        .ADDR_Q(addr_q),
        .DATA_RDATA(data_rdata),
        .CTRL_Q(ctrl_q),
        .RELOAD_Q(reload_q),
        .TIMER_COUNT(timer_count),
        .TIMER_IRQ(timer_irq)
    );
    epa_shadow i_epa_shadow ();
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 12000) begin
            miscompares++;
            end_sim();
        end
    end
    task check(input string nm, input epa_byte_t exp, input epa_byte_t got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Writes one register: sel 3 address, 2 data, 1 control, 0 reload.
    task put(input int sel, input epa_byte_t d);
        @(negedge ref_clk);
        wdata = d;
        {addr_wr, data_wr, ctrl_wr, reload_wr} = 4'h1 << sel;
        @(negedge ref_clk);
        {addr_wr, data_wr, ctrl_wr, reload_wr} = 4'h0;
    endtask
    task rd(input epa_byte_t a);
        @(negedge ref_clk);
        check("addr", a, addr_q);
        check("rdata", i_epa_shadow.mem[a], data_rdata);
        data_rd = 1'b1;
        @(negedge ref_clk);
        data_rd = 1'b0;
    endtask
    // Starts a page cycle; stray writes while busy must all be refused.
    task run(input epa_byte_t cw, input int ph, input logic stray);
        int        n;
        epa_byte_t c;
        n = 0;
        put(1, cw);
        check("count", 8'h01, timer_count);
        if (stray) begin
            put(3, 8'h04);
            put(0, 8'h09);
            put(2, 8'h80);
            n = 6;
        end
        while (ctrl_q[CTRL_BUSY_BIT] !== 1'b0 && n < 3000) begin
            @(negedge ref_clk);
            n++;
        end
        check("cycle_len_ok", 8'h01,
              8'(n >= ph * PHASE - 2 && n <= ph * PHASE + 16));
        check("ctrl", 8'h20, ctrl_q);
        check("reload", 8'h01, reload_q);
        c = timer_count;
        repeat (TIMER_DIVIDE + 8) @(negedge ref_clk);
        check("count", c, timer_count);
    endtask
    task t_write;
        check("ctrl", 8'h00, ctrl_q);
        put(0, 8'h01);
        check("reload", 8'h01, reload_q);
        put(1, 8'h04);
        put(3, 8'h05);
        put(2, 8'h11);
        put(2, 8'h22);
        put(2, 8'h40);
        put(2, 8'h04);
        check("addr", 8'h07, addr_q);
        run(8'h14, 1, 1'b0);
        i_epa_shadow.op(6'h01, 4'hE, 32'h4422_1100, 1'b0);
        check("addr", 8'h08, addr_q);
        put(3, 8'h04);
        rd(8'h04);
        rd(8'h05);
        rd(8'h06);
        rd(8'h07);
        rd(8'h08);
    endtask
    task t_erase_write;
        put(3, 8'h05);
        put(2, 8'h0F);
        run(8'h18, 2, 1'b1);
        i_epa_shadow.op(6'h01, 4'h2, 32'h0000_0F00, 1'b1);
        check("addr", 8'h06, addr_q);
        put(3, 8'h04);
        rd(8'h04);
        rd(8'h05);
        rd(8'h06);
    endtask
    task t_erase;
        put(3, 8'h07);
        put(2, 8'h5A);
        run(8'h1E, 1, 1'b0);
        i_epa_shadow.op(6'h01, 4'h8, 32'h0000_0000, 1'b1);
        check("addr", 8'h07, addr_q);
        rd(8'h07);
        put(1, 8'h12);
        check("ctrl", 8'h02, ctrl_q);
    endtask
    task t_irq;
        put(1, 8'h60);
        check("irq", 8'h00, {7'h00, timer_irq});
        deriv_irq_en = 1'b1;
        @(negedge ref_clk);
        @(negedge ref_clk);
        check("irq", 8'h01, {7'h00, timer_irq});
        put(1, 8'h40);
        @(negedge ref_clk);
        check("irq", 8'h00, {7'h00, timer_irq});
    endtask
    task end_sim;
        $display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        {rst, deriv_irq_en, data_rd} = 3'h4;
        {addr_wr, data_wr, ctrl_wr, reload_wr} = 4'h0;
        wdata = 8'h00;
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 1'b0;
        t_write();
        t_erase_write();
        t_erase();
        t_irq();
        end_sim();
    end
endmodule
